// ===== power_reduction_mode_control.sv
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
module power_reduction_mode_control
  import pwr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // avalon slave
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  output logic             irq_o,
  // cpu instruction stream
  input  wire logic        idle_instr_i,
  input  wire logic        deep_sleep_instruction_i,
  input  wire logic        interrupt_return_instruction_i,
  input  wire logic        irq_request_i,
  input  wire logic        bus_busy_i,
  input  wire logic        ready_seen_i,
  // pins and wake sources
  input  wire logic        hw_reset_input_n_i,
  input  wire logic        nmi_n_i,
  input  wire logic [7:0]  fast_ext_irq_pin_i,
  input  wire logic [7:0]  fast_ext_irq_en_i,
  input  wire logic [7:0]  fast_ext_irq_pol_i,
  input  wire logic        rtc_irq_i,
  input  wire logic        can_activity_i,
  input  wire logic        i2c_activity_i,
  input  wire logic        lp_osc_running_i,
  // power control
  output logic             cpu_halt_o,
  output logic             periph_clk_en_o,
  output logic             core_clk_en_o,
  output logic             main_osc_en_o,
  output logic             rtc_run_o,
  output logic             rtc_ref_lp_o,
  output logic             regulator_off_o,
  output logic             resume_pending_o,
  output logic             entry_refused_o
);
  typedef struct packed {
    pwr_state_t  st;
    logic        target_pd;
    logic        lp_ref;
    logic        resume;
    logic        refused;
    logic [3:0]  ev;
    logic        cpu_halt;
    logic        periph_en;
    logic        core_en;
    logic        main_osc;
    logic        rtc_run;
    logic        rtc_lp;
    logic        reg_off;
  } ctl_t;
  ctl_t s_r, s_nxt;

  logic [7:0]  ctrl;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  logic [31:0] status;
  logic        pin_wake;
  logic [7:0]  pin_active;
  logic        pins_quiet;
  logic        ready_ok;
  logic        int_wake;

  assign pin_active = ~(fast_ext_irq_pin_i ^ fast_ext_irq_pol_i) & fast_ext_irq_en_i;
  assign pins_quiet = ~|pin_active;
  assign ready_ok   = !ctrl[CTRL_READY_EN_BIT] ||
                      (ready_seen_i == ctrl[CTRL_READY_POL_BIT]);
  assign int_wake   = pin_wake || rtc_irq_i || can_activity_i || i2c_activity_i;
  assign status     = {22'h00_0000, s_r.st, s_r.lp_ref, s_r.resume, s_r.refused,
                       lp_osc_running_i, 1'b0};

  pwr_regs u_regs (
    .clk_i        (clk_i),
    .reset_i      (reset_i),
    .ce_i         (ce_i),
    .address_i    (address_i),
    .read_i       (read_i),
    .write_i      (write_i),
    .writedata_i  (writedata_i),
    .readdata_o   (readdata_o),
    .waitrequest_o(waitrequest_o),
    .status_i     (status),
    .events_i     (s_r.ev),
    .ctrl_o       (ctrl),
    .irq_stat_o   (irq_stat),
    .irq_mask_o   (irq_mask),
    .irq_o        (irq_o)
  );

  // a pulse that is not high at any rising clock edge is not caught
  pwr_wake_filter u_wake (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .pin_i   (pin_active),
    .enable_i(fast_ext_irq_en_i),
    .wake_o  (pin_wake)
  );

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ev = 4'h0;
    // latch running low-power osc until software disables it
    if (lp_osc_running_i && !ctrl[CTRL_LP_DIS_BIT])
      s_nxt.lp_ref = 1'b1;
    if (ctrl[CTRL_LP_DIS_BIT])
      s_nxt.lp_ref = 1'b0;
    if (interrupt_return_instruction_i)
      s_nxt.resume = 1'b0;
    unique case (s_r.st)
      ST_RUN:
      begin
        if (idle_instr_i || deep_sleep_instruction_i)
        begin
          s_nxt.target_pd = deep_sleep_instruction_i;
          s_nxt.st = ST_DRAIN;
          s_nxt.refused = 1'b0;
        end
      end
      ST_DRAIN:
      begin
        if (!bus_busy_i)
        begin
          s_nxt.st = ST_RUN;
          if (!ready_ok)
          begin
            s_nxt.refused = 1'b1;
            s_nxt.ev[EV_REFUSED] = 1'b1;
          end
          else if (!s_r.target_pd)
          begin
            s_nxt.st = ST_IDLE;
            s_nxt.ev[EV_IDLE_ENTER] = 1'b1;
          end
          else if (!ctrl[CTRL_VARIANT_BIT])
          begin
            if (!nmi_n_i)
            begin
              s_nxt.st = ST_PD_PROT;
              s_nxt.ev[EV_PD_ENTER] = 1'b1;
            end
            else
            begin
              s_nxt.refused = 1'b1;
              s_nxt.ev[EV_REFUSED] = 1'b1;
            end
          end
          else if (pins_quiet)
          begin
            s_nxt.st = ST_PD_INT;
            s_nxt.ev[EV_PD_ENTER] = 1'b1;
          end
          else
          begin
            s_nxt.refused = 1'b1;
            s_nxt.ev[EV_REFUSED] = 1'b1;
          end
        end
      end
      ST_IDLE:
      begin
        if (irq_request_i)
        begin
          s_nxt.st = ST_RUN;
          s_nxt.resume = 1'b1;
          s_nxt.ev[EV_WAKE] = 1'b1;
        end
      end
      ST_PD_PROT:
      begin
        s_nxt.st = ST_PD_PROT;
      end
      ST_PD_INT:
      begin
        if (int_wake)
        begin
          s_nxt.st = ST_RUN;
          s_nxt.ev[EV_WAKE] = 1'b1;
        end
      end
      default:
      begin
        s_nxt.st = ST_RUN;
      end
    endcase
    s_nxt.cpu_halt  = (s_nxt.st != ST_RUN) && (s_nxt.st != ST_DRAIN);
    s_nxt.periph_en = (s_nxt.st != ST_PD_PROT) && (s_nxt.st != ST_PD_INT);
    s_nxt.core_en   = s_nxt.periph_en;
    s_nxt.rtc_lp    = s_nxt.lp_ref;
    s_nxt.rtc_run   = s_nxt.periph_en || ctrl[CTRL_RTC_RUN_BIT];
    // main osc stops only with low-power reference
    s_nxt.main_osc  = s_nxt.periph_en || !s_nxt.lp_ref;
    s_nxt.reg_off   = !s_nxt.periph_en && ctrl[CTRL_REGOFF_BIT];
  end

  // reset from hw pin or system reset is the only exit of protected mode
  always_ff @(posedge clk_i)
  begin
    if (reset_i || !hw_reset_input_n_i)
    begin
      s_r.st        <= ST_RUN;
      s_r.target_pd <= 1'b0;
      s_r.lp_ref    <= 1'b0;
      s_r.resume    <= 1'b0;
      s_r.refused   <= 1'b0;
      s_r.ev        <= 4'h0;
      s_r.cpu_halt  <= 1'b0;
      s_r.periph_en <= 1'b1;
      s_r.core_en   <= 1'b1;
      s_r.main_osc  <= 1'b1;
      s_r.rtc_run   <= 1'b1;
      s_r.rtc_lp    <= 1'b0;
      s_r.reg_off   <= 1'b0;
    end
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign cpu_halt_o       = s_r.cpu_halt;
  assign periph_clk_en_o  = s_r.periph_en;
  assign core_clk_en_o    = s_r.core_en;
  assign main_osc_en_o    = s_r.main_osc;
  assign rtc_run_o        = s_r.rtc_run;
  assign rtc_ref_lp_o     = s_r.rtc_lp;
  assign regulator_off_o  = s_r.reg_off;
  assign resume_pending_o = s_r.resume;
  assign entry_refused_o  = s_r.refused;

  property p_idle_periph;
    @(posedge clk_i) disable iff (reset_i)
      (s_r.st == ST_IDLE) |-> (cpu_halt_o && periph_clk_en_o);
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("idle clocks wrong");

  property p_halt_run;
    @(posedge clk_i) disable iff (reset_i)
      (s_r.st == ST_RUN || s_r.st == ST_DRAIN) |-> !cpu_halt_o;
  endproperty
  a_halt_run: assert property (p_halt_run) else $error("cpu halted while running");

  property p_irq_level;
    @(posedge clk_i) disable iff (reset_i)
      irq_o == |(irq_stat & irq_mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_entry_instr;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      ($past(s_r.st) == ST_RUN && s_r.st == ST_DRAIN && $past(ce_i)) |->
        $past(idle_instr_i || deep_sleep_instruction_i);
  endproperty
  a_entry_instr: assert property (p_entry_instr) else $error("entry without instr");

  property p_bus_done;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (s_r.st == ST_DRAIN && bus_busy_i && ce_i) |=> (s_r.st == ST_DRAIN);
  endproperty
  a_bus_done: assert property (p_bus_done) else $error("left drain with bus busy");

  property p_ready_refuse;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (s_r.st == ST_DRAIN && !bus_busy_i && !ready_ok && ce_i) |=>
        (s_r.st == ST_RUN && entry_refused_o);
  endproperty
  a_ready_refuse: assert property (p_ready_refuse) else $error("ready refuse missed");

  sequence s_idle_irq;
    (s_r.st == ST_IDLE) && irq_request_i && ce_i;
  endsequence
  property p_idle_wake;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      s_idle_irq |=> (s_r.st == ST_RUN && resume_pending_o) ##1 !cpu_halt_o;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not woken");

  property p_pd_frozen;
    @(posedge clk_i) disable iff (reset_i)
      (s_r.st == ST_PD_PROT || s_r.st == ST_PD_INT) |-> (!core_clk_en_o && !periph_clk_en_o);
  endproperty
  a_pd_frozen: assert property (p_pd_frozen) else $error("clock running in power-down");

  property p_main_osc;
    @(posedge clk_i) disable iff (reset_i)
      (!periph_clk_en_o) |-> (main_osc_en_o == !rtc_ref_lp_o);
  endproperty
  a_main_osc: assert property (p_main_osc) else $error("main osc state wrong");

  property p_rtc_pd;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (!periph_clk_en_o && $past(ce_i)) |-> (rtc_run_o == $past(ctrl[CTRL_RTC_RUN_BIT]));
  endproperty
  a_rtc_pd: assert property (p_rtc_pd) else $error("rtc run state wrong");

  property p_lp_adopt;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (!reset_i && hw_reset_input_n_i && lp_osc_running_i && !ctrl[CTRL_LP_DIS_BIT] && ce_i)
        |=> rtc_ref_lp_o;
  endproperty
  a_lp_adopt: assert property (p_lp_adopt) else $error("low-power reference not adopted");

  sequence s_pin_refuse_cond;
    (s_r.st == ST_DRAIN) && !bus_busy_i && ready_ok && s_r.target_pd &&
      ctrl[CTRL_VARIANT_BIT] && !pins_quiet && ce_i;
  endsequence
  property p_pin_refuse;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      s_pin_refuse_cond |=> (s_r.st == ST_RUN && entry_refused_o);
  endproperty
  a_pin_refuse: assert property (p_pin_refuse) else $error("active pin entry not refused");

  property p_prot_stay;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (s_r.st == ST_PD_PROT) |=> (s_r.st == ST_PD_PROT);
  endproperty
  a_prot_stay: assert property (p_prot_stay) else $error("protected mode left");

  property p_int_wake;
    @(posedge clk_i) disable iff (reset_i || !hw_reset_input_n_i)
      (s_r.st == ST_PD_INT && int_wake && ce_i) |=> (s_r.st == ST_RUN) ##1 core_clk_en_o;
  endproperty
  a_int_wake: assert property (p_int_wake) else $error("interruptible not woken");
endmodule // power_reduction_mode_control

// ===== pwr_pkg.sv
package pwr_pkg;
  // register byte offsets
  localparam logic [3:0] OFS_CTRL      = 4'h0;
  localparam logic [3:0] OFS_STATUS    = 4'h4;
  localparam logic [3:0] OFS_IRQ_STAT  = 4'h8;
  localparam logic [3:0] OFS_IRQ_MASK  = 4'hC;
  // control register fields
  localparam int CTRL_VARIANT_BIT   = 5;
  localparam int CTRL_REGOFF_BIT    = 0;
  localparam int CTRL_RTC_RUN_BIT   = 1;
  localparam int CTRL_LP_DIS_BIT    = 2;
  localparam int CTRL_READY_EN_BIT  = 3;
  localparam int CTRL_READY_POL_BIT = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // interrupt status bits
  localparam int EV_IDLE_ENTER = 0;
  localparam int EV_PD_ENTER   = 1;
  localparam int EV_WAKE       = 2;
  localparam int EV_REFUSED    = 3;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  // fast interrupt pin minimum width
  localparam int CLK_PERIOD_NS  = 40;
  localparam int EXT_IRQ_MIN_NS = 40;
  localparam logic [1:0] EXT_IRQ_MIN_CYC =
    2'((EXT_IRQ_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  typedef enum logic [4:0] {
    ST_RUN     = 5'h01,
    ST_DRAIN   = 5'h02,
    ST_IDLE    = 5'h04,
    ST_PD_PROT = 5'h08,
    ST_PD_INT  = 5'h10
  } pwr_state_t;
endpackage

// ===== pwr_regs.sv
`timescale 1ns/1ps
module pwr_regs
  import pwr_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  // avalon slave
  input  wire logic [3:0]  address_i,
  input  wire logic        read_i,
  input  wire logic        write_i,
  input  wire logic [31:0] writedata_i,
  output logic [31:0]      readdata_o,
  output logic             waitrequest_o,
  // block side
  input  wire logic [31:0] status_i,
  input  wire logic [3:0]  events_i,
  output logic [7:0]       ctrl_o,
  output logic [3:0]       irq_stat_o,
  output logic [3:0]       irq_mask_o,
  output logic             irq_o
);
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [3:0]  stat;
    logic [3:0]  mask;
    logic        ack;
    logic        wreq;
    logic [31:0] rdata;
    logic        irq;
  } regs_t;
  regs_t s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = 1'b0;
    // set wins over write-one-to-clear
    if (write_i && !s_r.ack && address_i == OFS_IRQ_STAT)
      s_nxt.stat = s_r.stat & ~writedata_i[3:0];
    s_nxt.stat = s_nxt.stat | events_i;
    if ((read_i || write_i) && !s_r.ack)
    begin
      s_nxt.ack = 1'b1;
      s_nxt.rdata = 32'h0000_0000;
      if (write_i)
      begin
        if (address_i == OFS_CTRL)
          s_nxt.ctrl = writedata_i[7:0];
        if (address_i == OFS_IRQ_MASK)
          s_nxt.mask = writedata_i[3:0];
      end
      else
      begin
        unique case (address_i)
          OFS_CTRL:     s_nxt.rdata = {24'h00_0000, s_r.ctrl};
          OFS_STATUS:   s_nxt.rdata = status_i;
          OFS_IRQ_STAT: s_nxt.rdata = {28'h000_0000, s_r.stat};
          OFS_IRQ_MASK: s_nxt.rdata = {28'h000_0000, s_r.mask};
          default:      s_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    // registered wait: high while idle, low in the cycle after a request is taken
    s_nxt.wreq = !s_nxt.ack;
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_r.ctrl  <= CTRL_RESET;
      s_r.stat  <= IRQ_RESET;
      s_r.mask  <= IRQ_RESET;
      s_r.ack   <= 1'b0;
      s_r.wreq  <= 1'b1;
      s_r.rdata <= 32'h0000_0000;
      s_r.irq   <= 1'b0;
    end
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign readdata_o    = s_r.rdata;
  assign waitrequest_o = s_r.wreq;
  assign ctrl_o        = s_r.ctrl;
  assign irq_stat_o    = s_r.stat;
  assign irq_mask_o    = s_r.mask;
  assign irq_o         = s_r.irq;
endmodule // pwr_regs

// ===== pwr_wake_filter.sv
`timescale 1ns/1ps
module pwr_wake_filter
  import pwr_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       ce_i,
  input  wire logic [7:0] pin_i,
  input  wire logic [7:0] enable_i,
  output logic            wake_o
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        wake;
  } filt_t;
  filt_t s_r, s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.wake = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (pin_i[i] && enable_i[i])
      begin
        if (s_r.cnt[2*i +: 2] != EXT_IRQ_MIN_CYC)
          s_nxt.cnt[2*i +: 2] = s_r.cnt[2*i +: 2] + 2'h1;
      end
      else
        s_nxt.cnt[2*i +: 2] = 2'h0;
      if (s_nxt.cnt[2*i +: 2] == EXT_IRQ_MIN_CYC)
        s_nxt.wake = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      s_r <= '0;
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign wake_o = s_r.wake;
endmodule // pwr_wake_filter

// ===== cpu_pin_model.sv
`timescale 1ns/1ps
module cpu_pin_model (
  // clock
  input  wire logic clk_i,
  // instruction stream
  output logic       idle_o,
  output logic       sleep_o,
  output logic       iret_o,
  // levels and pins
  output logic       irq_o,
  output logic       busy_o,
  output logic       ready_o,
  output logic       rst_n_o,
  output logic       nmi_n_o,
  output logic       rtc_o,
  output logic       can_o,
  output logic       i2c_o,
  output logic       lp_osc_o,
  output logic [7:0] pin_o,
  output logic [7:0] en_o,
  output logic [7:0] pol_o
);
  initial
  begin
    {idle_o, sleep_o, iret_o, irq_o, busy_o, rtc_o, can_o, i2c_o} = 8'h00;
    {ready_o, rst_n_o, nmi_n_o, lp_osc_o} = 4'hF;
    pin_o = 8'h00;
    en_o  = 8'h04;
    pol_o = 8'hFF;
  end

  // one-cycle instruction pulse: 0 idle, 1 power-down, 2 return
  task automatic pulse(input int k);
    @(posedge clk_i);
    idle_o  <= (k == 0);
    sleep_o <= (k == 1);
    iret_o  <= (k == 2);
    @(posedge clk_i);
    {idle_o, sleep_o, iret_o} <= 3'h0;
  endtask

  task automatic lvl(input int k, input logic [7:0] v);
    @(posedge clk_i);
    case (k)
      0: irq_o    <= v[0];
      1: busy_o   <= v[0];
      2: ready_o  <= v[0];
      3: nmi_n_o  <= v[0];
      4: rtc_o    <= v[0];
      5: can_o    <= v[0];
      6: i2c_o    <= v[0];
      7: lp_osc_o <= v[0];
      8: pin_o    <= v;
      10: pol_o   <= v;
      default: en_o <= v;
    endcase
  endtask

  // fast pin held two full cycles, above the minimum width
  task automatic pin_pulse(input logic [7:0] v);
    lvl(8, v);
    repeat (2) @(posedge clk_i);
    pin_o <= 8'h00;
  endtask

  // reset pin low long enough for clocks to settle
  task automatic hw_reset();
    @(posedge clk_i);
    rst_n_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_o <= 1'b1;
  endtask
endmodule // cpu_pin_model

// ===== power_reduction_mode_control_tb.sv
`timescale 1ns/1ps
module power_reduction_mode_control_tb;
  import pwr_pkg::*;
  logic        clk_i, reset_i, read_i, write_i, irq_o, waitrequest_o;
  logic [3:0]  address_i;
  logic [31:0] writedata_i, readdata_o, q;
  logic        idle, sleep, iret, irq_req, busy, ready, rst_n, nmi_n;
  logic        rtc, can, i2c, lp_osc, ce;
  logic [7:0]  pin, en, pol;
  logic [8:0]  outs;
  int          failures, num_checks;

  cpu_pin_model cpu (.clk_i(clk_i), .idle_o(idle), .sleep_o(sleep), .iret_o(iret),
    .irq_o(irq_req), .busy_o(busy), .ready_o(ready), .rst_n_o(rst_n), .nmi_n_o(nmi_n),
    .rtc_o(rtc), .can_o(can), .i2c_o(i2c), .lp_osc_o(lp_osc), .pin_o(pin), .en_o(en),
    .pol_o(pol));

  power_reduction_mode_control DUT (.clk_i(clk_i), .reset_i(reset_i), .ce_i(ce),
    .address_i(address_i), .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .irq_o(irq_o),
    .idle_instr_i(idle), .deep_sleep_instruction_i(sleep),
    .interrupt_return_instruction_i(iret), .irq_request_i(irq_req), .bus_busy_i(busy),
    .ready_seen_i(ready), .hw_reset_input_n_i(rst_n), .nmi_n_i(nmi_n),
    .fast_ext_irq_pin_i(pin), .fast_ext_irq_en_i(en), .fast_ext_irq_pol_i(pol),
    .rtc_irq_i(rtc), .can_activity_i(can), .i2c_activity_i(i2c),
    .lp_osc_running_i(lp_osc), .cpu_halt_o(outs[8]), .periph_clk_en_o(outs[7]),
    .core_clk_en_o(outs[6]), .main_osc_en_o(outs[5]), .rtc_run_o(outs[4]),
    .rtc_ref_lp_o(outs[3]), .regulator_off_o(outs[2]), .resume_pending_o(outs[1]),
    .entry_refused_o(outs[0]));

  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    read_i      <= !wr;
    write_i     <= wr;
    address_i   <= a;
    writedata_i <= d;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk_i);
      if (waitrequest_o === 1'b0)
        break;
    end
    if (k == 20)
    begin
      failures++;
      $display("Error %0t: bus access hung", $time);
      stop_test();
    end
    q = readdata_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp, 32'hFFFFFFFF);
  endtask

  // outputs settle within a few edges of the causing input
  task automatic see(input logic [8:0] exp, input logic [8:0] m);
    repeat (4) @(posedge clk_i);
    chk({23'h0, outs}, {23'h0, exp}, {23'h0, m});
  endtask

  initial
  begin
    {read_i, write_i, address_i, writedata_i} = '0;
    ce         = 1'b1;
    failures   = 0;
    num_checks = 0;
    reset_i    = 1'b1;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    see(9'h0F8, 9'h1FF);
    rd(OFS_CTRL, 32'h0);
    rd(OFS_IRQ_MASK, 32'h0);
    rd(OFS_STATUS, 32'h32);
    rd(4'h2, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h04);
    see(9'h0F0, 9'h1FF);
    bus(1'b1, OFS_CTRL, 32'h03);
    // idle waits for the external bus to finish
    cpu.lvl(1, 8'h01);
    cpu.pulse(0);
    see(9'h0F8, 9'h1FF);
    cpu.lvl(1, 8'h00);
    see(9'h1F8, 9'h1FF);
    // a low clock enable holds idle against a pending interrupt
    @(posedge clk_i) ce <= 1'b0;
    cpu.lvl(0, 8'h01);
    see(9'h1F8, 9'h1FF);
    @(posedge clk_i) ce <= 1'b1;
    see(9'h0FA, 9'h1FF);
    cpu.lvl(0, 8'h00);
    cpu.pulse(2);
    see(9'h0F8, 9'h1FF);
    rd(OFS_IRQ_STAT, 32'h5);
    chk({31'h0, irq_o}, 32'h0, 32'h1);
    bus(1'b1, OFS_IRQ_MASK, 32'hF);
    see(9'h0F8, 9'h1FF);
    chk({31'h0, irq_o}, 32'h1, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h5);
    see(9'h0F8, 9'h1FF);
    rd(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq_o}, 32'h0, 32'h1);
    // ready enabled at high polarity: not seen refuses idle, then seen but outside nmi refuses power-down
    bus(1'b1, OFS_CTRL, 32'h1B);
    cpu.lvl(2, 8'h00);
    cpu.pulse(0);
    see(9'h0F9, 9'h1FF);
    cpu.lvl(2, 8'h01);
    cpu.pulse(1);
    see(9'h0F9, 9'h1FF);
    // protected power-down from inside the nmi handler
    cpu.lvl(3, 8'h00);
    cpu.pulse(1);
    see(9'h11C, 9'h1FF);
    cpu.lvl(3, 8'h01);
    cpu.lvl(0, 8'h01);
    cpu.lvl(4, 8'h01);
    cpu.pin_pulse(8'h04);
    see(9'h11C, 9'h1FF);
    cpu.lvl(0, 8'h00);
    cpu.lvl(4, 8'h00);
    cpu.hw_reset();
    see(9'h0F8, 9'h1FF);
    rd(OFS_IRQ_STAT, 32'hA);
    // interruptible power-down on the main oscillator
    bus(1'b1, OFS_CTRL, 32'h27);
    cpu.lvl(7, 8'h00);
    cpu.lvl(8, 8'h04);
    cpu.pulse(1);
    see(9'h0F1, 9'h1FF);
    cpu.lvl(8, 8'h00);
    // enabled pin active low at a low level also refuses entry
    cpu.lvl(10, 8'hFB);
    cpu.pulse(1);
    see(9'h0F1, 9'h1FF);
    cpu.lvl(10, 8'hFF);
    cpu.lvl(9, 8'h00);
    // wake by rtc, can and i2c, then by a fast pin
    for (int s = 4; s <= 7; s++)
    begin
      cpu.pulse(1);
      see(9'h134, 9'h1FF);
      if (s == 7)
        cpu.pin_pulse(8'h04);
      else
        cpu.lvl(s, 8'h01);
      see(9'h0F0, 9'h1FD);
      if (s != 7)
        cpu.lvl(s, 8'h00);
      cpu.lvl(9, 8'h04);
    end
    cpu.pulse(1);
    see(9'h134, 9'h1FF);
    cpu.hw_reset();
    see(9'h0F0, 9'h1FD);
    stop_test();
  end
endmodule // power_reduction_mode_control_tb
